//--- rtl/srs_consts.svh
// Offsets, reset values and timing constants of the speed reference selector.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SRS_ADDR_SRC 8'h00
`define SRS_ADDR_PSEL 8'h04
`define SRS_ADDR_AUTO_DIS 8'h08
`define SRS_ADDR_SCAN_INT 8'h0C
`define SRS_ADDR_DEST_A 8'h10
`define SRS_ADDR_DEST_B 8'h14
`define SRS_ADDR_GROUP 8'h18
`define SRS_ADDR_INDEX 8'h1C
`define SRS_ADDR_CTRL 8'h20
`define SRS_PRESET_PAGE 3'h2
// ----------------------------------------
// Reset values and field limits
// ----------------------------------------
`define SRS_SRC_RESET 3'h0
`define SRS_PSEL_RESET 4'h0
`define SRS_AUTO_DIS_RESET 1'h1
`define SRS_SCAN_INT_RESET 16'h0001
`define SRS_SRC_MAX 3'h5
`define SRS_PSEL_FIRST 4'h1
`define SRS_PSEL_LOW 4'h2
`define SRS_PSEL_HIGH 4'h8
`define SRS_PSEL_SCAN 4'h9
`define SRS_GROUP_A1 3'h1
`define SRS_GROUP_A2 3'h2
`define SRS_INDEX_NONE 4'h0
`define SRS_INDEX_FIRST 4'h1
`define SRS_CTRL_DRV_RST 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define SRS_CLK_PERIOD_NS 10
`define SRS_SCAN_TICK_NS 1000000
`endif

//--- rtl/srs_if.sv
// Internal carrier between the selector core, its scan timer and terminal logic.
// Assumes all parties run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface srs_if #(parameter int INT_W = 16);
  logic scan_en;
  logic [INT_W-1:0] scan_interval;
  logic [2:0] scan_step;
  logic pin_a;
  logic pin_b;
  logic term_a;
  logic term_b;
  srs_pkg::srs_src_t cfg_src;
  logic auto_disable;
  srs_pkg::srs_func_t man_a;
  srs_pkg::srs_func_t man_b;
  srs_pkg::srs_func_t dest_a;
  srs_pkg::srs_func_t dest_b;
  modport core (output scan_en, scan_interval, pin_a, pin_b, cfg_src, auto_disable, man_a,
    man_b, input scan_step, term_a, term_b, dest_a, dest_b);
  modport scan (input scan_en, scan_interval, output scan_step);
  modport term (input pin_a, pin_b, cfg_src, auto_disable, man_a, man_b,
    output term_a, term_b, dest_a, dest_b);
endinterface
`default_nettype wire

//--- rtl/srs_pkg.sv
// Types shared by the speed reference selector modules.
// Assumes nothing beyond a SystemVerilog compiler.
package srs_pkg;
  typedef enum logic [2:0] {
    SRC_ANALOG_ONE_OR_TWO = 3'b000,
    SRC_ANALOG_ONE_OR_PRESET = 3'b001,
    SRC_ANALOG_TWO_OR_PRESET = 3'b010,
    SRC_PRESETS_ONLY = 3'b011,
    SRC_KEYPAD = 3'b100,
    SRC_PRECISION = 3'b101
  } srs_src_t;
  typedef enum logic [1:0] {
    FUNC_NONE = 2'b00,
    FUNC_ANALOG_SELECT = 2'b01,
    FUNC_PRESET_BIT0 = 2'b10,
    FUNC_PRESET_BIT1 = 2'b11
  } srs_func_t;
endpackage

//--- rtl/srs_scan.sv
// Preset scan timer: steps 0..7 at a programmable number of ticks.
// Assumes scan_en and scan_interval come from registers on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module srs_scan #(
  parameter int TICK_CYCLES = 100000,
  parameter int INT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Core side
  srs_if.scan s
);
  localparam int PRE_W = $clog2(TICK_CYCLES) + 1;
  logic [PRE_W-1:0] pre;
  logic [INT_W-1:0] ticks;
  logic [2:0] step;
  wire tick = s.scan_en && (pre == PRE_W'(TICK_CYCLES - 1));
  wire [INT_W:0] ticks_inc = {1'b0, ticks} + 1'b1;
  // Interval 0 behaves as 1 so the scan never freezes
  wire advance = tick && (ticks_inc >= {1'b0, s.scan_interval});
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre <= '0;
      ticks <= '0;
      step <= 3'h0;
    end else if (!s.scan_en) begin
      pre <= '0;
      ticks <= '0;
      step <= 3'h0;
    end else begin
      pre <= tick ? '0 : PRE_W'(pre + 1'b1);
      ticks <= advance ? '0 : (tick ? ticks_inc[INT_W-1:0] : ticks);
      step <= advance ? 3'(step + 3'h1) : step;
    end
  end
  assign s.scan_step = step;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_SCAN_STEP: assert property ($past(s.scan_en) && s.scan_en && $changed(step)
    |-> step == 3'($past(step) + 3'h1)) else $error("Scan step skipped");
  AST_SCAN_GAP: assert property (s.scan_en && advance |-> ticks_inc >= {1'b0, s.scan_interval})
    else $error("Scan stepped early");
  AST_SCAN_OFF: assert property (!s.scan_en |=> step == 3'h0)
    else $error("Scan step held while disabled");
  CVR_SCAN_WRAP: cover property (s.scan_en && step == 3'h7 ##1 step == 3'h0);
endmodule
`default_nettype wire

//--- rtl/srs_term.sv
// Selection terminal synchronisers and destination assignment.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module srs_term (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Core side
  srs_if.term t
);
  logic [1:0] sync1;
  logic [1:0] sync2;
  function automatic srs_pkg::srs_func_t auto_func(input srs_pkg::srs_src_t src,
    input logic second);
    if (src == srs_pkg::SRC_ANALOG_ONE_OR_TWO) begin
      auto_func = second ? srs_pkg::FUNC_NONE : srs_pkg::FUNC_ANALOG_SELECT;
    end else if (src <= srs_pkg::SRC_PRESETS_ONLY) begin
      auto_func = second ? srs_pkg::FUNC_PRESET_BIT1 : srs_pkg::FUNC_PRESET_BIT0;
    end else begin
      auto_func = srs_pkg::FUNC_NONE;
    end
  endfunction
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= {t.pin_b, t.pin_a};
      sync2 <= sync1;
    end
  end
  assign t.term_a = sync2[0];
  assign t.term_b = sync2[1];
  // Auto set-up follows the source latched at drive reset, not the live one
  assign t.dest_a = t.auto_disable ? t.man_a : auto_func(t.cfg_src, 1'b0);
  assign t.dest_b = t.auto_disable ? t.man_b : auto_func(t.cfg_src, 1'b1);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_AUTO_DEST: assert property (!t.auto_disable |-> t.dest_a == auto_func(t.cfg_src, 1'b0)
    && t.dest_b == auto_func(t.cfg_src, 1'b1)) else $error("Auto destination wrong");
endmodule
`default_nettype wire

//--- rtl/srs_top.sv
// Speed reference selector: register file, active reference choice and indicators.
// Assumes a single-cycle register port on clk_sys and asynchronous terminal pins.
//
// Overview of operation
// - Auto-config derives terminal destinations from source selector.
// - Manual destination writes only when auto disabled.
// - Source change reaches terminals after drive reset.
// - Source selector has six codes, resets zero.
// - Modes 0-2, preset 2-8 selects that preset.
// - Presets-only mode, preset 1-8 selects directly.
// - Preset selector 9 enables the scan timer.
// - Scan steps analog (preset 1 in presets-only mode), then presets 2 to 8.
// - Scan step interval equals scan interval setting.
// - Auto-config disable bit defaults to one.
// - Eight preset values held in consecutive registers.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "srs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srs_top #(
  parameter int REF_W = 16,
  parameter int INT_W = 16,
  parameter int SCAN_TICK_CYCLES = (`SRS_SCAN_TICK_NS + `SRS_CLK_PERIOD_NS - 1)
    / `SRS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Selection terminals
  input wire logic select_terminal_a,
  input wire logic select_terminal_b,
  // Reference sources
  input wire logic [REF_W-1:0] analog_one_ref,
  input wire logic [REF_W-1:0] analog_two_ref,
  input wire logic [REF_W-1:0] keypad_ref,
  input wire logic [REF_W-1:0] precision_ref,
  // Selected reference and indicators
  output logic [REF_W-1:0] active_reference,
  output logic [2:0] reference_group_indicator,
  output logic [3:0] preset_index_indicator,
  output logic [1:0] terminal_a_destination,
  output logic [1:0] terminal_b_destination
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  srs_pkg::srs_src_t reference_source_select;
  logic [3:0] preset_reference_select;
  logic terminal_autoconfig_disable;
  logic [INT_W-1:0] scan_interval_setting;
  srs_pkg::srs_func_t man_a;
  srs_pkg::srs_func_t man_b;
  srs_pkg::srs_src_t cfg_src;
  logic [REF_W-1:0] preset_value [0:7];

  srs_if #(.INT_W(INT_W)) bus_i ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire wr_src = reg_wr && (reg_addr == `SRS_ADDR_SRC);
  wire wr_psel = reg_wr && (reg_addr == `SRS_ADDR_PSEL);
  wire wr_dis = reg_wr && (reg_addr == `SRS_ADDR_AUTO_DIS);
  wire wr_int = reg_wr && (reg_addr == `SRS_ADDR_SCAN_INT);
  wire wr_dest_a = reg_wr && (reg_addr == `SRS_ADDR_DEST_A);
  wire wr_dest_b = reg_wr && (reg_addr == `SRS_ADDR_DEST_B);
  wire preset_hit = (reg_addr[7:5] == `SRS_PRESET_PAGE) && (reg_addr[1:0] == 2'h0);
  wire wr_preset = reg_wr && preset_hit;
  wire [2:0] preset_slot = reg_addr[4:2];
  // Out-of-range codes are dropped so the selectors always hold a legal value
  wire src_ok = reg_wdata[2:0] <= `SRS_SRC_MAX;
  wire psel_ok = reg_wdata[3:0] <= `SRS_PSEL_SCAN;
  // Software drive reset: the only moment auto-config picks up a new source
  wire drive_reset = reg_wr && (reg_addr == `SRS_ADDR_CTRL)
    && reg_wdata[`SRS_CTRL_DRV_RST];
  // Manual destinations are frozen while the automatic set-up owns them
  wire man_we = terminal_autoconfig_disable;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reference_source_select <= srs_pkg::srs_src_t'(`SRS_SRC_RESET);
      preset_reference_select <= `SRS_PSEL_RESET;
      terminal_autoconfig_disable <= `SRS_AUTO_DIS_RESET;
      scan_interval_setting <= INT_W'(`SRS_SCAN_INT_RESET);
    end else begin
      if (wr_src && src_ok) begin
        reference_source_select <= srs_pkg::srs_src_t'(reg_wdata[2:0]);
      end
      if (wr_psel && psel_ok) begin
        preset_reference_select <= reg_wdata[3:0];
      end
      if (wr_dis) begin
        terminal_autoconfig_disable <= reg_wdata[0];
      end
      if (wr_int) begin
        scan_interval_setting <= reg_wdata[INT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      man_a <= srs_pkg::FUNC_NONE;
      man_b <= srs_pkg::FUNC_NONE;
    end else begin
      if (wr_dest_a && man_we) begin
        man_a <= srs_pkg::srs_func_t'(reg_wdata[1:0]);
      end
      if (wr_dest_b && man_we) begin
        man_b <= srs_pkg::srs_func_t'(reg_wdata[1:0]);
      end
    end
  end

  // Hardware reset leaves the selector at its reset code, so this matches it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_src <= srs_pkg::srs_src_t'(`SRS_SRC_RESET);
    end else if (drive_reset) begin
      cfg_src <= reference_source_select;
    end
  end

  // Preset values are not reset; software loads them before use
  always_ff @(posedge clk_sys) begin
    if (wr_preset) begin
      preset_value[preset_slot] <= reg_wdata[REF_W-1:0];
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  assign bus_i.scan_en = preset_reference_select == `SRS_PSEL_SCAN;
  assign bus_i.scan_interval = scan_interval_setting;
  assign bus_i.pin_a = select_terminal_a;
  assign bus_i.pin_b = select_terminal_b;
  assign bus_i.cfg_src = cfg_src;
  assign bus_i.auto_disable = terminal_autoconfig_disable;
  assign bus_i.man_a = man_a;
  assign bus_i.man_b = man_b;

  srs_scan #(.TICK_CYCLES(SCAN_TICK_CYCLES), .INT_W(INT_W)) u_scan (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .s(bus_i.scan)
  );

  srs_term u_term (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .t(bus_i.term)
  );

  // ----------------------------------------
  // Active reference selection
  // ----------------------------------------
  wire [2:0] src = reference_source_select;
  wire [3:0] psel = preset_reference_select;
  wire analog_mode = src == srs_pkg::SRC_ANALOG_ONE_OR_TWO;
  wire binary_mode = (src >= srs_pkg::SRC_ANALOG_ONE_OR_PRESET)
    && (src <= srs_pkg::SRC_PRESETS_ONLY);
  wire presets_only = src == srs_pkg::SRC_PRESETS_ONLY;
  wire fixed_mode = src >= srs_pkg::SRC_KEYPAD;
  // A terminal acts only through the function its destination gives it
  wire pick_analog_two = (bus_i.dest_a == srs_pkg::FUNC_ANALOG_SELECT && bus_i.term_a)
    || (bus_i.dest_b == srs_pkg::FUNC_ANALOG_SELECT && bus_i.term_b);
  wire bit0 = (bus_i.dest_a == srs_pkg::FUNC_PRESET_BIT0 && bus_i.term_a)
    || (bus_i.dest_b == srs_pkg::FUNC_PRESET_BIT0 && bus_i.term_b);
  wire bit1 = (bus_i.dest_a == srs_pkg::FUNC_PRESET_BIT1 && bus_i.term_a)
    || (bus_i.dest_b == srs_pkg::FUNC_PRESET_BIT1 && bus_i.term_b);
  wire psel_fixed = (psel >= `SRS_PSEL_LOW) && (psel <= `SRS_PSEL_HIGH);
  wire psel_direct = presets_only && (psel >= `SRS_PSEL_FIRST)
    && (psel <= `SRS_PSEL_HIGH);
  wire psel_scan = psel == `SRS_PSEL_SCAN;
  wire psel_binary = binary_mode && (psel == `SRS_PSEL_RESET);
  wire [3:0] scan_index = 4'(bus_i.scan_step) + `SRS_INDEX_FIRST;
  wire [3:0] binary_index = `SRS_INDEX_FIRST + {2'h0, bit1, bit0};

  wire [3:0] next_index = fixed_mode ? `SRS_INDEX_NONE :
    (psel_fixed || psel_direct) ? psel :
    psel_scan ? scan_index :
    psel_binary ? binary_index :
    `SRS_INDEX_FIRST;
  wire [2:0] next_group = analog_mode ?
    (pick_analog_two ? `SRS_GROUP_A2 : `SRS_GROUP_A1) : src;
  wire use_analog = !fixed_mode && !presets_only && (next_index == `SRS_INDEX_FIRST);
  wire [2:0] preset_pick = 3'(next_index - `SRS_INDEX_FIRST);
  wire [REF_W-1:0] next_reference =
    (src == srs_pkg::SRC_KEYPAD) ? keypad_ref :
    (src == srs_pkg::SRC_PRECISION) ? precision_ref :
    use_analog ? ((next_group == `SRS_GROUP_A2) ? analog_two_ref : analog_one_ref) :
    preset_value[preset_pick];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      active_reference <= '0;
      reference_group_indicator <= `SRS_GROUP_A1;
      preset_index_indicator <= `SRS_INDEX_FIRST;
      terminal_a_destination <= 2'h0;
      terminal_b_destination <= 2'h0;
    end else begin
      active_reference <= next_reference;
      reference_group_indicator <= next_group;
      preset_index_indicator <= next_index;
      terminal_a_destination <= bus_i.dest_a;
      terminal_b_destination <= bus_i.dest_b;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [31:0] rd_mux =
    (reg_addr == `SRS_ADDR_SRC) ? {29'h0, reference_source_select} :
    (reg_addr == `SRS_ADDR_PSEL) ? {28'h0, preset_reference_select} :
    (reg_addr == `SRS_ADDR_AUTO_DIS) ? {31'h0, terminal_autoconfig_disable} :
    (reg_addr == `SRS_ADDR_SCAN_INT) ? 32'(scan_interval_setting) :
    (reg_addr == `SRS_ADDR_DEST_A) ? {30'h0, bus_i.dest_a} :
    (reg_addr == `SRS_ADDR_DEST_B) ? {30'h0, bus_i.dest_b} :
    (reg_addr == `SRS_ADDR_GROUP) ? {29'h0, reference_group_indicator} :
    (reg_addr == `SRS_ADDR_INDEX) ? {28'h0, preset_index_indicator} :
    preset_hit ? 32'(preset_value[preset_slot]) :
    32'h0;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_SRC_LEGAL: assert property (reference_source_select <= srs_pkg::SRC_PRECISION)
    else $error("Source selector out of range");
  AST_MAN_LOCK: assert property (wr_dest_a && !terminal_autoconfig_disable |=> $stable(man_a))
    else $error("Manual destination changed under auto set-up");
  AST_DEFER: assert property (!drive_reset |=> $stable(cfg_src))
    else $error("Terminal set-up followed source without drive reset");
  AST_DRV_RESET: assert property (drive_reset |=> cfg_src == $past(reference_source_select))
    else $error("Drive reset did not latch source");
  AST_PRESET_FIX: assert property (src <= srs_pkg::SRC_ANALOG_TWO_OR_PRESET && psel_fixed
    |=> preset_index_indicator == $past(psel)) else $error("Fixed preset not selected");
  AST_PRESET_DIRECT: assert property (psel_direct |=> preset_index_indicator == $past(psel)
    && reference_group_indicator == 3'h3) else $error("Direct preset not selected");
  AST_SCAN_INDEX: assert property (psel_scan && !fixed_mode
    |=> preset_index_indicator == 4'($past(bus_i.scan_step)) + 4'h1)
    else $error("Scan index wrong");
  AST_BINARY: assert property (psel_binary |=> preset_index_indicator ==
    4'h1 + {2'h0, $past(bit1), $past(bit0)}) else $error("Binary preset wrong");
  AST_ANALOG_PICK: assert property (analog_mode && psel <= 4'h1 |=> preset_index_indicator
    == 4'h1 && reference_group_indicator == ($past(pick_analog_two) ? 3'h2 : 3'h1))
    else $error("Analog pick wrong");
  AST_DIS_RESET: assert property ($rose(reset_n) |-> terminal_autoconfig_disable)
    else $error("Auto-config disable not at default");
  AST_RD_ONCE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("Read data outside read cycle");

  // Indicator outputs are the registered copy of the effective destinations
  AST_DEST_OUT: assert property (##1 terminal_a_destination == $past(bus_i.dest_a)
    && terminal_b_destination == $past(bus_i.dest_b))
    else $error("Destination outputs do not follow effective set-up");
  AST_MAN_LOCK_B: assert property (wr_dest_b && !terminal_autoconfig_disable |=> $stable(man_b))
    else $error("Manual destination B changed under auto set-up");
  // A refused write must never leave an undecodable preset selector behind
  AST_PSEL_LEGAL: assert property (preset_reference_select <= `SRS_PSEL_SCAN)
    else $error("Preset selector out of range");

  // Keypad and precision sources bypass terminals and presets entirely
  AST_FIXED_GROUP: assert property (fixed_mode |=> preset_index_indicator == `SRS_INDEX_NONE
    && reference_group_indicator == $past(src))
    else $error("Fixed source indicators wrong");
  AST_KEYPAD_REF: assert property (src == srs_pkg::SRC_KEYPAD
    |=> active_reference == $past(keypad_ref))
    else $error("Keypad reference not selected");
  AST_PRECISION_REF: assert property (src == srs_pkg::SRC_PRECISION
    |=> active_reference == $past(precision_ref))
    else $error("Precision reference not selected");
  AST_ANALOG_TWO_REF: assert property (analog_mode && pick_analog_two
    && psel <= `SRS_PSEL_FIRST |=> active_reference == $past(analog_two_ref))
    else $error("Analog input 2 not selected");

  CVR_ANALOG_TWO: cover property (analog_mode && pick_analog_two);
  CVR_PRESET_FOUR: cover property (psel_binary && bit0 && bit1);
  CVR_KEYPAD: cover property (src == srs_pkg::SRC_KEYPAD ##1 reference_group_indicator == 3'h4);
  CVR_MANUAL: cover property (wr_dest_a && man_we);
endmodule
`default_nettype wire

//--- sim/speed_reference_selector_tb.sv
// Self-checking bench for the speed reference selector top.
// Assumes a scan tick shortened to 4 clocks and contacts from srs_contacts.
`include "srs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module speed_reference_selector_tb;
  logic clk_sys;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic select_terminal_a;
  logic select_terminal_b;
  logic close_a;
  logic close_b;
  logic [15:0] an1 = 16'h0A11;
  logic [15:0] an2 = 16'h0A22;
  logic [15:0] kp = 16'h0B33;
  logic [15:0] pr = 16'h0C44;
  logic [15:0] active_reference;
  logic [2:0] group;
  logic [3:0] index;
  logic [1:0] dest_a;
  logic [1:0] dest_b;
  int mismatches;
  int total_checks;

  srs_top #(.REF_W(16), .INT_W(16), .SCAN_TICK_CYCLES(4)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .select_terminal_a(select_terminal_a), .select_terminal_b(select_terminal_b),
    .analog_one_ref(an1), .analog_two_ref(an2), .keypad_ref(kp), .precision_ref(pr),
    .active_reference(active_reference), .reference_group_indicator(group),
    .preset_index_indicator(index), .terminal_a_destination(dest_a),
    .terminal_b_destination(dest_b));

  srs_contacts partner (.clk_sys(clk_sys), .close_a(close_a), .close_b(close_b),
    .select_terminal_a(select_terminal_a), .select_terminal_b(select_terminal_b));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [15:0] pv(input int n);
    return 16'(n) * 16'h1100;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    rd(`SRS_ADDR_SRC, d); chk(d, 32'h0);
    rd(`SRS_ADDR_PSEL, d); chk(d, 32'h0);
    rd(`SRS_ADDR_AUTO_DIS, d); chk(d, 32'h1);
    rd(8'h3C, d); chk(d, 32'h0);
    for (int n = 1; n <= 8; n++) begin
      wr(8'h40 + 8'(4 * (n - 1)), {16'h0, pv(n)});
    end
    for (int n = 1; n <= 8; n++) begin
      rd(8'h40 + 8'(4 * (n - 1)), d); chk(d, {16'h0, pv(n)});
    end
  endtask
  task automatic t_analog;
    wr(`SRS_ADDR_AUTO_DIS, 32'h0);
    settle(3); chk({30'h0, dest_a}, 32'h1);
    for (int p = 0; p <= 1; p++) begin
      wr(`SRS_ADDR_PSEL, 32'(p));
      for (int a = 0; a <= 1; a++) begin
        close_a <= a[0];
        settle(6); chk({16'h0, active_reference}, {16'h0, a ? an2 : an1});
        chk({29'h0, group}, a ? 32'h2 : 32'h1);
      end
    end
    close_a <= 1'b0;
  endtask
  task automatic t_presets;
    for (int s = 0; s <= 3; s++) begin
      wr(`SRS_ADDR_SRC, 32'(s));
      for (int p = (s == 3) ? 1 : 2; p <= 8; p++) begin
        wr(`SRS_ADDR_PSEL, 32'(p));
        settle(3); chk({16'h0, active_reference}, {16'h0, pv(p)});
        chk({28'h0, index}, 32'(p));
      end
    end
  endtask
  task automatic t_binary;
    logic [31:0] d;
    wr(`SRS_ADDR_SRC, 32'h1);
    wr(`SRS_ADDR_PSEL, 32'h0);
    // Source change must not move the terminal functions before a drive reset
    settle(3); chk({30'h0, dest_a}, 32'h1);
    wr(`SRS_ADDR_CTRL, 32'h1);
    settle(3); chk({28'h0, dest_b, dest_a}, 32'hE);
    for (int k = 0; k <= 3; k++) begin
      close_a <= k[0];
      close_b <= k[1];
      settle(6); chk({28'h0, index}, 32'(k + 1));
      chk({16'h0, active_reference}, {16'h0, (k == 0) ? an1 : pv(k + 1)});
    end
    close_a <= 1'b0;
    close_b <= 1'b0;
    wr(`SRS_ADDR_DEST_A, 32'h0);
    rd(`SRS_ADDR_DEST_A, d); chk(d, 32'h2);
    wr(`SRS_ADDR_AUTO_DIS, 32'h1);
    wr(`SRS_ADDR_DEST_A, 32'h1);
    rd(`SRS_ADDR_DEST_A, d); chk(d, 32'h1);
  endtask
  task automatic t_other;
    logic [31:0] d;
    for (int s = 4; s <= 5; s++) begin
      wr(`SRS_ADDR_SRC, 32'(s));
      settle(3); chk({29'h0, group}, 32'(s));
      chk({28'h0, index}, 32'h0);
      chk({16'h0, active_reference}, {16'h0, (s == 4) ? kp : pr});
    end
    wr(`SRS_ADDR_SRC, 32'h6);
    rd(`SRS_ADDR_SRC, d); chk(d, 32'h5);
    wr(`SRS_ADDR_PSEL, 32'hA);
    rd(`SRS_ADDR_PSEL, d); chk(d, 32'h0);
  endtask
  task automatic t_scan;
    logic [3:0] prev;
    int n;
    wr(`SRS_ADDR_SRC, 32'h1);
    wr(`SRS_ADDR_SCAN_INT, 32'h2);
    wr(`SRS_ADDR_PSEL, 32'h9);
    settle(3);
    prev = index;
    n = 0;
    while (index === prev && n < 40) begin
      settle(1);
      n++;
    end
    for (int k = 0; k < 9; k++) begin
      prev = index;
      n = 0;
      while (index === prev && n < 40) begin
        settle(1);
        n++;
      end
      // Two ticks of four clocks between steps
      chk(32'(n), 32'd8);
      chk({28'h0, index}, (prev == 4'h8) ? 32'h1 : 32'(prev + 4'h1));
      if (index == 4'h1) begin
        chk({16'h0, active_reference}, {16'h0, an1});
      end
    end
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    // Whole run is about 400 cycles; fifty times that is a hang
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    close_a = 1'b0;
    close_b = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_analog();
    t_presets();
    t_binary();
    t_other();
    t_scan();
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- sim/srs_contacts.sv
// External contact model for the two selection terminals.
// Assumes the bench requests contact states just after a rising clk_sys edge.
`timescale 1ns/1ps
`default_nettype none
module srs_contacts (
  // Clock
  input wire logic clk_sys,
  // Requests from the bench
  input wire logic close_a,
  input wire logic close_b,
  // Contact lines
  output var logic select_terminal_a,
  output var logic select_terminal_b
);
  // An open contact reads low through its pull-down, so lines start at 0
  initial begin
    select_terminal_a = 1'b0;
    select_terminal_b = 1'b0;
  end
  always @(posedge clk_sys) begin
    select_terminal_a <= close_a;
    select_terminal_b <= close_b;
  end
endmodule
`default_nettype wire
